//--- include/sse_defines.svh
// Register indices, field positions, masks and reset values of the SMI source enable and status block.
// Assumes a 32-bit classic Wishbone slave: byte address is four times the register index.
//
// Summary of operation
// - Bits 7..0 of the interrupt-request enable register enable SMI on assertion of IRQ15..IRQ8.
// - Bits 7,6,5,3,2,1,0 of the DMA-request enable register enable SMI on assertion of DREQ7,6,5,3,2,1,0.
// - Bit 4 of the DMA-request enable register enables SMI on assertion of any DMA request.
// - Every bit of both enable registers resets to zero, so no request line raises SMI after reset.
// - Both enable registers are read/write and read back the value last written.
// - The access status register flags which peripheral or memory access caused the SMI.
// - Writing one to an access status bit clears it; writing zero leaves it.
// - Bits 7..2 of the timer/trap status register flag timer timeouts, PCI master request and NMI.
// - Bits 7..2 of the timer/trap status register clear on a write of one and ignore a write of zero.
// - Bits 1..0 of the timer/trap status register flag I/O traps 2 and 1 and clear when read.
// - All bits of both status registers reset to zero.
// - Individual DMA-request enables act only while the global DMA-request enable bit 5 is set.
// - Individual interrupt-request enables act only while the global interrupt-request enable bit 4 is set.
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

`define SSE_ADR_W 10
`define SSE_IDX_ACC_EN 8'h70
`define SSE_IDX_TT_EN 8'h71
`define SSE_IDX_GLB_EN 8'h72
`define SSE_IDX_IRQ_EN 8'h74
`define SSE_IDX_DMA_EN 8'h75
`define SSE_IDX_ACC_ST 8'h76
`define SSE_IDX_TT_ST 8'h77
`define SSE_IDX_IRQ_ST 8'h7a
`define SSE_IDX_DMA_ST 8'h7b

`define SSE_RST_BYTE 8'h00
`define SSE_GLB_MASK 8'h30
`define SSE_GLB_DMA_BIT 5
`define SSE_GLB_IRQ_BIT 4
`define SSE_DMA_ANY_BIT 4
`define SSE_DMA_CHAN_MASK 8'hef
`define SSE_DMA_ANY_MASK 8'h10
`define SSE_TT_W1C_MASK 8'hfc
`define SSE_TT_RC_MASK 8'h03
`define SSE_TTEN_NMI_BIT 3
`define SSE_TTEN_PCI_BIT 2

`endif

//--- include/sse_pkg.sv
// Types shared by the SMI source enable and status block.
// Assumes the constants header is included by the design file.
package sse_pkg;

    typedef logic [7:0] sse_byte_t;

    typedef enum {
        SSE_SEL_NONE,
        SSE_SEL_ACC_EN,
        SSE_SEL_TT_EN,
        SSE_SEL_GLB_EN,
        SSE_SEL_IRQ_EN,
        SSE_SEL_DMA_EN,
        SSE_SEL_ACC_ST,
        SSE_SEL_TT_ST,
        SSE_SEL_IRQ_ST,
        SSE_SEL_DMA_ST
    } sse_reg_sel_t;

endpackage : sse_pkg

//--- rtl/sse_top.sv
// SMI source enable masks, cause status registers and the combined SMI output.
// Assumes a classic Wishbone master on clk_i, event pulses and request levels synchronous to clk_i.
`timescale 1ns/1ps
`include "sse_defines.svh"

module sse_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SSE_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic [7:0] acc_evt_i,
    input wire logic [7:0] tt_evt_i,
    input wire logic [7:0] irq_hi_i,
    input wire logic [7:0] dreq_i,
    output logic smi_o
);

    // Bus handshake and SMI output state
    logic ack_r;
    logic [31:0] dat_r;
    logic smi_r;

    // Enable registers
    sse_pkg::sse_byte_t acc_en_r;
    sse_pkg::sse_byte_t tt_en_r;
    sse_pkg::sse_byte_t glb_en_r;
    sse_pkg::sse_byte_t irq_en_r;
    sse_pkg::sse_byte_t dma_en_r;

    // Status registers
    sse_pkg::sse_byte_t acc_st_r;
    sse_pkg::sse_byte_t tt_st_r;
    sse_pkg::sse_byte_t irq_st_r;
    sse_pkg::sse_byte_t dma_st_r;
    sse_pkg::sse_byte_t acc_st_nxt;
    sse_pkg::sse_byte_t tt_st_nxt;
    sse_pkg::sse_byte_t irq_st_nxt;
    sse_pkg::sse_byte_t dma_st_nxt;

    // Previous request levels for edge detection
    sse_pkg::sse_byte_t irq_prev_r;
    sse_pkg::sse_byte_t dreq_prev_r;

    // Decode and strobes
    sse_pkg::sse_reg_sel_t reg_sel;
    logic req;
    logic take;
    logic wr_lo;
    logic rd_take;
    sse_pkg::sse_byte_t wr_byte;
    sse_pkg::sse_byte_t rd_byte;

    // Event and clear vectors
    sse_pkg::sse_byte_t tt_en_map;
    sse_pkg::sse_byte_t irq_rise;
    sse_pkg::sse_byte_t dreq_rise;
    sse_pkg::sse_byte_t acc_set;
    sse_pkg::sse_byte_t tt_set;
    sse_pkg::sse_byte_t irq_set;
    sse_pkg::sse_byte_t dma_set;
    sse_pkg::sse_byte_t acc_clr;
    sse_pkg::sse_byte_t tt_clr;
    sse_pkg::sse_byte_t irq_clr;
    sse_pkg::sse_byte_t dma_clr;
    sse_pkg::sse_byte_t dma_act;
    logic irq_glb;
    logic dma_glb;
    logic smi_nxt;

    // Sticky update: a set in the same cycle as a clear wins
    function automatic sse_pkg::sse_byte_t sse_sticky(
        input sse_pkg::sse_byte_t cur,
        input sse_pkg::sse_byte_t set,
        input sse_pkg::sse_byte_t clr
    );
        sse_sticky = (cur & ~clr) | set;
    endfunction : sse_sticky

    assign req = wb_cyc_i & wb_stb_i;
    // Effects happen at the edge where the master samples ack high
    assign take = req & ack_r;
    assign wr_lo = take & wb_we_i & wb_sel_i[0];
    assign rd_take = take & ~wb_we_i;
    assign wr_byte = wb_dat_i[7:0];

    // Register decode on the word index
    always_comb begin
        case (wb_adr_i[`SSE_ADR_W-1:2])
            `SSE_IDX_ACC_EN: reg_sel = sse_pkg::SSE_SEL_ACC_EN;
            `SSE_IDX_TT_EN: reg_sel = sse_pkg::SSE_SEL_TT_EN;
            `SSE_IDX_GLB_EN: reg_sel = sse_pkg::SSE_SEL_GLB_EN;
            `SSE_IDX_IRQ_EN: reg_sel = sse_pkg::SSE_SEL_IRQ_EN;
            `SSE_IDX_DMA_EN: reg_sel = sse_pkg::SSE_SEL_DMA_EN;
            `SSE_IDX_ACC_ST: reg_sel = sse_pkg::SSE_SEL_ACC_ST;
            `SSE_IDX_TT_ST: reg_sel = sse_pkg::SSE_SEL_TT_ST;
            `SSE_IDX_IRQ_ST: reg_sel = sse_pkg::SSE_SEL_IRQ_ST;
            `SSE_IDX_DMA_ST: reg_sel = sse_pkg::SSE_SEL_DMA_ST;
            default: reg_sel = sse_pkg::SSE_SEL_NONE;
        endcase
    end

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        case (reg_sel)
            sse_pkg::SSE_SEL_ACC_EN: rd_byte = acc_en_r;
            sse_pkg::SSE_SEL_TT_EN: rd_byte = tt_en_r;
            sse_pkg::SSE_SEL_GLB_EN: rd_byte = glb_en_r;
            sse_pkg::SSE_SEL_IRQ_EN: rd_byte = irq_en_r;
            sse_pkg::SSE_SEL_DMA_EN: rd_byte = dma_en_r;
            sse_pkg::SSE_SEL_ACC_ST: rd_byte = acc_st_r;
            sse_pkg::SSE_SEL_TT_ST: rd_byte = tt_st_r;
            sse_pkg::SSE_SEL_IRQ_ST: rd_byte = irq_st_r;
            sse_pkg::SSE_SEL_DMA_ST: rd_byte = dma_st_r;
            default: rd_byte = `SSE_RST_BYTE;
        endcase
    end

    // Acknowledge one cycle after the request, drop it the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Read data is captured as ack rises and held through the ack cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req & ~ack_r & ~wb_we_i) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    // Access-cause enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_en_r <= `SSE_RST_BYTE;
        end else if (wr_lo && reg_sel == sse_pkg::SSE_SEL_ACC_EN) begin
            acc_en_r <= wr_byte;
        end
    end

    // Timer, NMI, PCI master and trap enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tt_en_r <= `SSE_RST_BYTE;
        end else if (wr_lo && reg_sel == sse_pkg::SSE_SEL_TT_EN) begin
            tt_en_r <= wr_byte;
        end
    end

    // Global request enables, only bits 5 and 4 are kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            glb_en_r <= `SSE_RST_BYTE;
        end else if (wr_lo && reg_sel == sse_pkg::SSE_SEL_GLB_EN) begin
            glb_en_r <= wr_byte & `SSE_GLB_MASK;
        end
    end

    // IRQ15..IRQ8 enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r <= `SSE_RST_BYTE;
        end else if (wr_lo && reg_sel == sse_pkg::SSE_SEL_IRQ_EN) begin
            irq_en_r <= wr_byte;
        end
    end

    // DMA request enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_en_r <= `SSE_RST_BYTE;
        end else if (wr_lo && reg_sel == sse_pkg::SSE_SEL_DMA_EN) begin
            dma_en_r <= wr_byte;
        end
    end

    // Request lines raise a cause on assertion, not while held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_prev_r <= `SSE_RST_BYTE;
            dreq_prev_r <= `SSE_RST_BYTE;
        end else begin
            irq_prev_r <= irq_hi_i;
            dreq_prev_r <= dreq_i;
        end
    end

    assign irq_rise = irq_hi_i & ~irq_prev_r;
    assign dreq_rise = dreq_i & ~dreq_prev_r;
    assign irq_glb = glb_en_r[`SSE_GLB_IRQ_BIT];
    assign dma_glb = glb_en_r[`SSE_GLB_DMA_BIT];

    // NMI and PCI master enables sit swapped against their status bits
    always_comb begin
        tt_en_map = tt_en_r;
        tt_en_map[`SSE_TTEN_NMI_BIT] = tt_en_r[`SSE_TTEN_PCI_BIT];
        tt_en_map[`SSE_TTEN_PCI_BIT] = tt_en_r[`SSE_TTEN_NMI_BIT];
    end

    // Set terms gated by enables
    always_comb begin
        acc_set = acc_evt_i & acc_en_r;
        tt_set = tt_evt_i & tt_en_map;
        irq_set = irq_rise & irq_en_r & {8{irq_glb}};
        dma_set = dreq_rise & dma_en_r & `SSE_DMA_CHAN_MASK & {8{dma_glb}};
        dma_set[`SSE_DMA_ANY_BIT] = (|dreq_rise) & dma_en_r[`SSE_DMA_ANY_BIT] & dma_glb;
    end

    // Clear terms; a read clears only the trap bits it returned
    always_comb begin
        acc_clr = `SSE_RST_BYTE;
        tt_clr = `SSE_RST_BYTE;
        irq_clr = `SSE_RST_BYTE;
        dma_clr = `SSE_RST_BYTE;
        if (wr_lo && reg_sel == sse_pkg::SSE_SEL_ACC_ST) begin
            acc_clr = wr_byte;
        end
        if (wr_lo && reg_sel == sse_pkg::SSE_SEL_TT_ST) begin
            tt_clr = wr_byte & `SSE_TT_W1C_MASK;
        end
        if (rd_take && reg_sel == sse_pkg::SSE_SEL_TT_ST) begin
            tt_clr = tt_clr | (dat_r[7:0] & `SSE_TT_RC_MASK);
        end
        if (wr_lo && reg_sel == sse_pkg::SSE_SEL_IRQ_ST) begin
            irq_clr = wr_byte;
        end
        if (wr_lo && reg_sel == sse_pkg::SSE_SEL_DMA_ST) begin
            dma_clr = wr_byte;
        end
    end

    assign acc_st_nxt = sse_sticky(acc_st_r, acc_set, acc_clr);
    assign tt_st_nxt = sse_sticky(tt_st_r, tt_set, tt_clr);
    assign irq_st_nxt = sse_sticky(irq_st_r, irq_set, irq_clr);
    assign dma_st_nxt = sse_sticky(dma_st_r, dma_set, dma_clr);

    // Access-cause status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_st_r <= `SSE_RST_BYTE;
        end else begin
            acc_st_r <= acc_st_nxt;
        end
    end

    // Timer and trap cause status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tt_st_r <= `SSE_RST_BYTE;
        end else begin
            tt_st_r <= tt_st_nxt;
        end
    end

    // IRQ15..IRQ8 cause status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_r <= `SSE_RST_BYTE;
        end else begin
            irq_st_r <= irq_st_nxt;
        end
    end

    // DMA request cause status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_st_r <= `SSE_RST_BYTE;
        end else begin
            dma_st_r <= dma_st_nxt;
        end
    end

    // Request causes still count only while their group is globally enabled
    assign dma_act = dma_st_r & dma_en_r & {8{dma_glb}};
    assign smi_nxt = (|(acc_st_r & acc_en_r)) |
                     (|(tt_st_r & tt_en_map)) |
                     (|(irq_st_r & irq_en_r & {8{irq_glb}})) |
                     (|dma_act);

    // SMI is a level while any enabled cause is recorded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smi_r <= 1'b0;
        end else begin
            smi_r <= smi_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign smi_o = smi_r;

endmodule : sse_top

//--- tb/sse_chk.sv
// Concurrent checks on the ports of the SMI source enable and status block.
// Assumes one clock clk_i and a synchronous active-high reset rst_i.
`timescale 1ns/1ps
`include "sse_defines.svh"

module sse_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`SSE_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [7:0] acc_evt_i,
    input wire logic [7:0] tt_evt_i,
    input wire logic [7:0] irq_hi_i,
    input wire logic [7:0] dreq_i,
    input wire logic smi_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h7f;
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_rd_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
    a_unmapped_zero: assert property (s_rd_unmapped |-> wb_dat_o == 32'h00000000) else $error("unmapped read not 0");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !smi_o && wb_dat_o == 32'h0)
        else $error("outputs active after reset");
    // An enable write acts at its ack edge, so SMI can rise two edges later
    a_smi_rise_cause: assert property ($rose(smi_o) |-> $past(wb_ack_o && wb_we_i, 2) ||
        $past(acc_evt_i != 8'h00 || tt_evt_i != 8'h00 || irq_hi_i != 8'h00 || dreq_i != 8'h00, 2))
        else $error("smi rose without cause");
    a_smi_fall_cause: assert property ($fell(smi_o) |-> $past(wb_ack_o && wb_cyc_i, 2))
        else $error("smi fell without access");
endmodule : sse_chk

bind sse_top sse_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .acc_evt_i, .tt_evt_i, .irq_hi_i, .dreq_i, .smi_o);

//--- tb/sse_req_model.sv
// Request lines of the system interrupt and DMA controllers, as levels.
// Assumes the bench commands which lines stand asserted.
`timescale 1ns/1ps

module sse_req_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] irq_cmd_i,
    input wire logic [7:0] dma_cmd_i,
    output logic [7:0] irq_hi_o,
    output logic [7:0] dreq_o
);
    // Lines change only at the clock, as the real controllers do
    always_ff @(posedge clk_i) begin
        irq_hi_o <= rst_i ? 8'h00 : irq_cmd_i;
        dreq_o <= rst_i ? 8'h00 : dma_cmd_i;
    end
endmodule : sse_req_model

//--- tb/tb_top.sv
// Self-checking bench of the SMI source enable and status block.
// Assumes a classic Wishbone slave answering one cycle after request.
`timescale 1ns/1ps

module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, smi;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0] acc = 8'h00, tt = 8'h00, irq_cmd = 8'h00, dma_cmd = 8'h00, irq, dreq, d;
    int n_fail = 0, n_checks = 0;
    sse_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .acc_evt_i(acc), .tt_evt_i(tt),
        .irq_hi_i(irq), .dreq_i(dreq), .smi_o(smi));
    sse_req_model u_req (.clk_i(clk_i), .rst_i(rst_i), .irq_cmd_i(irq_cmd), .dma_cmd_i(dma_cmd),
        .irq_hi_o(irq), .dreq_o(dreq));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t smi got %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] v);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, v};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
        d = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk8(d, exp);
    endtask : rd_chk
    task settle;
        repeat (4) @(posedge clk_i);
    endtask : settle
    task t_reset;
        logic [7:0] idx [6] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h7a, 8'h7b};
        foreach (idx[i]) rd_chk(idx[i], 8'h00);
        chk1(smi, 1'b0);
    endtask : t_reset
    task t_rw;
        xfer(1'b1, 8'h74, 8'ha5);
        xfer(1'b1, 8'h75, 8'h5a);
        xfer(1'b1, 8'h7f, 8'hff);
        rd_chk(8'h74, 8'ha5);
        rd_chk(8'h75, 8'h5a);
        rd_chk(8'h7f, 8'h00);
    endtask : t_rw
    task t_irq;
        xfer(1'b1, 8'h74, 8'hfe);
        xfer(1'b1, 8'h72, 8'h00);
        irq_cmd <= 8'h80;
        settle();
        rd_chk(8'h7a, 8'h00);
        irq_cmd <= 8'h00;
        xfer(1'b1, 8'h72, 8'h10);
        irq_cmd <= 8'h81;
        settle();
        rd_chk(8'h7a, 8'h80);
        chk1(smi, 1'b1);
        xfer(1'b1, 8'h7a, 8'h80);
        settle();
        chk1(smi, 1'b0);
        irq_cmd <= 8'h00;
    endtask : t_irq
    task t_dma;
        xfer(1'b1, 8'h75, 8'h01);
        dma_cmd <= 8'h01;
        settle();
        rd_chk(8'h7b, 8'h00);
        dma_cmd <= 8'h00;
        xfer(1'b1, 8'h72, 8'h30);
        dma_cmd <= 8'h03;
        settle();
        rd_chk(8'h7b, 8'h01);
        xfer(1'b1, 8'h7b, 8'hff);
        xfer(1'b1, 8'h75, 8'h10);
        dma_cmd <= 8'h43;
        settle();
        rd_chk(8'h7b, 8'h10);
        xfer(1'b1, 8'h7b, 8'hff);
        xfer(1'b1, 8'h72, 8'h00);
        dma_cmd <= 8'h00;
    endtask : t_dma
    task t_status;
        xfer(1'b1, 8'h70, 8'hff);
        xfer(1'b1, 8'h71, 8'hff);
        @(posedge clk_i);
        acc <= 8'h81;
        tt <= 8'hff;
        @(posedge clk_i);
        acc <= 8'h00;
        tt <= 8'h00;
        settle();
        chk1(smi, 1'b1);
        rd_chk(8'h76, 8'h81);
        xfer(1'b1, 8'h76, 8'h01);
        rd_chk(8'h76, 8'h80);
        rd_chk(8'h77, 8'hff);
        // That read has already cleared the trap bits
        xfer(1'b1, 8'h77, 8'hf0);
        rd_chk(8'h77, 8'h0c);
        xfer(1'b1, 8'h77, 8'h0c);
        @(posedge clk_i);
        tt <= 8'h03;
        @(posedge clk_i);
        tt <= 8'h00;
        settle();
        xfer(1'b1, 8'h77, 8'hff);
        rd_chk(8'h77, 8'h03);
        rd_chk(8'h77, 8'h00);
        // NMI enable sits at bit 3 but reports at status bit 2
        xfer(1'b1, 8'h71, 8'h08);
        @(posedge clk_i);
        tt <= 8'h0c;
        @(posedge clk_i);
        tt <= 8'h00;
        settle();
        rd_chk(8'h77, 8'h04);
        xfer(1'b1, 8'h77, 8'h04);
        xfer(1'b1, 8'h76, 8'h80);
        settle();
        chk1(smi, 1'b0);
    endtask : t_status
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_rw();
        t_irq();
        t_dma();
        t_status();
        report_and_stop();
    end
endmodule : tb_top
